// >>> host_model.sv
module host_model (
  input wire logic ref_clk,
  input wire logic [7:0] host_bus_out,
  input wire logic [7:0] host_bus_oe,
  output lcd_port_pkg::host_ctrl_t host_ctrl,
  output logic [7:0] host_bus_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_port_pkg::*;
  logic drv_en = 1'b0;
  logic [7:0] drv_val = 8'h00;
  logic [7:0] idle_val = 8'hA5;
  logic ena_mode = 1'b0;
  logic cs_block = 1'b0;
  // ==========
  // bus level
  // released lines toggle so no stale byte survives
  assign host_bus_in = host_bus_oe[0] ? host_bus_out : (drv_en ? drv_val : idle_val);
  always @(posedge ref_clk) idle_val <= ~idle_val;
  initial host_ctrl = 7'h2C;
  // cs_block leaves the high select inactive
  task automatic sel(input logic on);
    host_ctrl.chip_select_low_n <= !on;
    host_ctrl.chip_select_high <= on & !cs_block;
  endtask
  // first strap is set one clock before the second
  task automatic straps(input logic f, input logic s);
    @(posedge ref_clk);
    ena_mode <= f & s;
    host_ctrl.rd_strobe_n <= !(f & s);
    host_ctrl.iface_strap_first <= f;
    @(posedge ref_clk);
    host_ctrl.iface_strap_second <= s;
    repeat (2) @(posedge ref_clk);
  endtask
  // one parallel byte, either strobe style
  task automatic xfer(input logic rd, input logic cds, input logic [7:0] wb,
                      output logic [7:0] rb);
    @(posedge ref_clk);
    sel(1'b1);
    host_ctrl.cmd_data_select <= cds;
    drv_en <= !rd;
    drv_val <= wb;
    if (ena_mode) begin
      host_ctrl.rd_strobe_n <= 1'b1;
      host_ctrl.wr_strobe_n <= rd;
    end else if (rd) begin
      host_ctrl.rd_strobe_n <= 1'b0;
    end else begin
      host_ctrl.wr_strobe_n <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    rb = host_bus_in;
    host_ctrl.rd_strobe_n <= !ena_mode;
    host_ctrl.wr_strobe_n <= 1'b1;
    @(posedge ref_clk);
    sel(1'b0);
    drv_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  // serial frame, msb first; clock low at frame start and end
  task automatic ser_byte(input logic cds, input logic [7:0] b, input int nbits);
    @(posedge ref_clk);
    sel(1'b1);
    host_ctrl.cmd_data_select <= cds;
    drv_en <= 1'b1;
    drv_val <= 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      @(posedge ref_clk);
      drv_val <= {b[i], 7'h00};
      @(posedge ref_clk);
      drv_val[6] <= 1'b1;
    end
    @(posedge ref_clk);
    drv_val <= 8'h00;
    @(posedge ref_clk);
    sel(1'b0);
    drv_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule // host_model

// >>> lcd_host_port.sv
// How it works
// - eight two-way host bus lines, read and write
// - serial data on line 7, clock on 6
// - select low is command, high is data
// - transfers only with both chip selects active
// - separate-strobe mode drives bus while read low
// - enable-strobe mode honours direction only while enable high
// - enable-strobe direction high means host read
// - enable-strobe direction low means host write
// - straps 0,1 pick separate-strobe mode
// - straps 1,1 pick enable-strobe mode
// - straps 1,0 serial; 0,0 reset state
// - power command switches bias on-chip or external
// - select and direction decode to four access kinds
// - serial mode gives no data or status reads
// - serial samples line 7 on clock rise, msb first
// - deselect clears serial shifter and bit counter
//
// The register addresses and the APB slave port were chosen for this implementation.
module lcd_host_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] host_bus_in,
  output logic [7:0] host_bus_out,
  output logic [7:0] host_bus_oe,
  input wire lcd_port_pkg::host_ctrl_t host_ctrl,
  output logic bias_on_chip,
  input wire lcd_port_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import lcd_port_pkg::*;

  // ==================================================
  // access decode shared by reads and writes
  function automatic kind_t xfer_kind(input logic data_sel, input logic is_read);
    if (data_sel) xfer_kind = is_read ? K_DATA_RD : K_DATA_WR;
    else xfer_kind = is_read ? K_STAT_RD : K_CMD_WR;
  endfunction

  mode_t mode_reg;
  host_ctrl_t ctrl_q;
  logic [7:0] bus_q;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] status_byte_reg;
  logic [7:0] read_byte_reg;
  logic [7:0] cmd_last_reg;
  logic [7:0] cmd_cnt_reg;
  logic [7:0] data_last_reg;
  logic [7:0] data_cnt_reg;
  logic bias_reg;
  logic [7:0] out_reg;
  logic [7:0] oe_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // ==================================================
  // mode and chip select
  mode_t strap_mode;
  logic selected;
  logic in_reset;
  assign strap_mode = host_ctrl.iface_strap_first
    ? (host_ctrl.iface_strap_second ? MODE_ENA : MODE_SER)
    : (host_ctrl.iface_strap_second ? MODE_SEP : MODE_RESET);
  assign selected = ~host_ctrl.chip_select_low_n & host_ctrl.chip_select_high;
  assign in_reset = (mode_reg == MODE_RESET);

  // ==================================================
  // parallel strobes
  logic sep_rd, sep_wr, ena_rd, ena_wr;
  logic par_rd, par_wr;
  assign sep_rd = (mode_reg == MODE_SEP) & selected & ~host_ctrl.rd_strobe_n;
  assign sep_wr = (mode_reg == MODE_SEP) & selected & ~ctrl_q.wr_strobe_n
    & host_ctrl.wr_strobe_n;
  // enable strobe rides on the read pin, direction on the write pin
  assign ena_rd = (mode_reg == MODE_ENA) & selected & host_ctrl.rd_strobe_n
    & host_ctrl.wr_strobe_n;
  assign ena_wr = (mode_reg == MODE_ENA) & selected & ctrl_q.rd_strobe_n
    & ~host_ctrl.rd_strobe_n & ~ctrl_q.wr_strobe_n;
  assign par_rd = sep_rd | ena_rd;
  assign par_wr = sep_wr | ena_wr;

  // ==================================================
  // serial receiver
  logic sclk_rise, byte_done;
  logic [7:0] ser_byte;
  assign sclk_rise = (mode_reg == MODE_SER) & selected & host_bus_in[SER_CLK_BIT]
    & ~bus_q[SER_CLK_BIT];
  assign ser_byte = {shift_reg[6:0], host_bus_in[SER_DATA_BIT]};
  assign byte_done = sclk_rise & (bit_cnt_reg == SER_LAST_BIT);

  // ==================================================
  // write steering and read data
  logic wr_evt, wr_cds;
  logic [7:0] wr_byte;
  kind_t wr_kind, rd_kind;
  logic pwr_cmd;
  logic [7:0] out_next, oe_next;
  assign wr_evt = (par_wr | byte_done) & ~in_reset;
  assign wr_byte = byte_done ? ser_byte : bus_q; // data held through the strobe
  assign wr_cds = byte_done ? host_ctrl.cmd_data_select : ctrl_q.cmd_data_select;
  assign wr_kind = xfer_kind(wr_cds, 1'b0);
  assign rd_kind = xfer_kind(host_ctrl.cmd_data_select, 1'b1);
  assign pwr_cmd = wr_evt & (wr_kind == K_CMD_WR)
    & ((wr_byte & PWR_CTRL_MASK) == PWR_CTRL_CODE);
  assign out_next = (rd_kind == K_DATA_RD) ? read_byte_reg : status_byte_reg;
  assign oe_next = par_rd ? 8'hFF : 8'h00;

  // ==================================================
  // apb decode
  logic apb_setup_done, apb_commit, addr_ok;
  logic [31:0] rd_word;
  assign apb_setup_done = apb_req.psel & apb_req.penable & ~pready_reg;
  assign apb_commit = apb_req.psel & apb_req.penable & pready_reg;

  // register read mux and address check
  always_comb begin
    rd_word = 32'h0000_0000;
    addr_ok = 1'b1;
    if (apb_req.paddr == STATUS_BYTE_ADDR) begin
      rd_word = {24'h00_0000, status_byte_reg};
    end else if (apb_req.paddr == READ_BYTE_ADDR) begin
      rd_word = {24'h00_0000, read_byte_reg};
    end else if (apb_req.paddr == CMD_LAST_ADDR) begin
      rd_word = {16'h0000, cmd_cnt_reg, cmd_last_reg};
    end else if (apb_req.paddr == DATA_LAST_ADDR) begin
      rd_word = {16'h0000, data_cnt_reg, data_last_reg};
    end else if (apb_req.paddr == PORT_STATE_ADDR) begin
      rd_word = {26'h000_0000, bit_cnt_reg, bias_reg, mode_reg};
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ==================================================
  // pin sampling and mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
      ctrl_q <= '0;
      ctrl_q.rd_strobe_n <= 1'b1; // strobes rest high, no false edge after reset
      ctrl_q.wr_strobe_n <= 1'b1;
      bus_q <= 8'h00;
    end else begin
      mode_reg <= strap_mode;
      ctrl_q <= host_ctrl;
      bus_q <= host_bus_in;
    end
  end

  // serial shifter, cleared whenever deselected
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else if (!selected || mode_reg != MODE_SER) begin
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else if (sclk_rise) begin
      shift_reg <= ser_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // captured command and display bytes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_last_reg <= 8'h00;
      cmd_cnt_reg <= 8'h00;
      data_last_reg <= 8'h00;
      data_cnt_reg <= 8'h00;
    end else if (wr_evt && wr_kind == K_CMD_WR) begin
      cmd_last_reg <= wr_byte;
      cmd_cnt_reg <= cmd_cnt_reg + 8'h01;
    end else if (wr_evt) begin
      data_last_reg <= wr_byte;
      data_cnt_reg <= data_cnt_reg + 8'h01;
    end
  end

  // bias supply mode, back to external in reset state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bias_reg <= BIAS_ON_CHIP_RST;
    end else if (in_reset) begin
      bias_reg <= BIAS_ON_CHIP_RST;
    end else if (pwr_cmd) begin
      bias_reg <= (wr_byte[2:0] != PWR_OFF_FIELD);
    end
  end

  // host bus drivers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_reg <= 8'h00;
      oe_reg <= 8'h00;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  // apb slave, one wait state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_setup_done;
      if (apb_setup_done) begin
        prdata_reg <= apb_req.pwrite ? 32'h0000_0000 : rd_word;
        pslverr_reg <= ~addr_ok;
      end
    end
  end

  // software-owned read-back bytes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_byte_reg <= STATUS_BYTE_RST;
      read_byte_reg <= READ_BYTE_RST;
    end else if (apb_commit && apb_req.pwrite) begin
      if (apb_req.paddr == STATUS_BYTE_ADDR) status_byte_reg <= apb_req.pwdata[7:0];
      if (apb_req.paddr == READ_BYTE_ADDR) read_byte_reg <= apb_req.pwdata[7:0];
    end
  end

  assign host_bus_out = out_reg;
  assign host_bus_oe = oe_reg;
  assign bias_on_chip = bias_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ==================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence ena_write_s;
    (mode_reg == MODE_ENA) && selected && host_ctrl.rd_strobe_n && !host_ctrl.wr_strobe_n
      ##1 (mode_reg == MODE_ENA) && selected && !host_ctrl.rd_strobe_n;
  endsequence

  sequence ser_bit_s;
    (mode_reg == MODE_SER) && selected && !host_bus_in[SER_CLK_BIT]
      ##1 (mode_reg == MODE_SER) && selected && host_bus_in[SER_CLK_BIT];
  endsequence

  sep_read_drive_a: assert property (
    (mode_reg == MODE_SEP) && selected && !host_ctrl.rd_strobe_n |=> host_bus_oe == 8'hFF)
    else $error("bus not driven during separate-strobe read");
  deselect_release_a: assert property (
    !selected |=> host_bus_oe == 8'h00)
    else $error("bus driven while deselected");
  serial_no_read_a: assert property (
    (mode_reg == MODE_SER) |=> host_bus_oe == 8'h00)
    else $error("bus driven in serial mode");
  ena_low_ignore_a: assert property (
    (mode_reg == MODE_ENA) && !host_ctrl.rd_strobe_n |=> host_bus_oe == 8'h00)
    else $error("bus driven with enable low");
  ena_read_a: assert property (
    (mode_reg == MODE_ENA) && selected && host_ctrl.rd_strobe_n && host_ctrl.wr_strobe_n
      |=> host_bus_oe == 8'hFF && host_bus_out == $past(out_next))
    else $error("enable-strobe read not served");
  ena_write_a: assert property (
    ena_write_s |=> (cmd_cnt_reg != $past(cmd_cnt_reg)) || (data_cnt_reg != $past(data_cnt_reg)))
    else $error("enable-strobe write lost");
  strap_decode_a: assert property (
    host_ctrl.iface_strap_first == 1'b0 && host_ctrl.iface_strap_second
      |=> mode_reg == MODE_SEP)
    else $error("strap decode wrong for separate-strobe");
  strap_ena_ser_a: assert property (
    host_ctrl.iface_strap_first |=> mode_reg == (($past(host_ctrl.iface_strap_second))
      ? MODE_ENA : MODE_SER))
    else $error("strap decode wrong");
  reset_state_a: assert property (
    in_reset |=> !bias_on_chip && host_bus_oe == 8'h00)
    else $error("reset state not held");
  cmd_steer_a: assert property (
    wr_evt && !wr_cds |=> cmd_last_reg == $past(wr_byte) && data_last_reg == $past(data_last_reg))
    else $error("command byte misrouted");
  data_steer_a: assert property (
    wr_evt && wr_cds |=> data_last_reg == $past(wr_byte) && cmd_last_reg == $past(cmd_last_reg))
    else $error("display byte misrouted");
  read_select_a: assert property (
    par_rd |=> host_bus_out == ($past(host_ctrl.cmd_data_select)
      ? $past(read_byte_reg) : $past(status_byte_reg)))
    else $error("read byte from wrong source");
  ser_shift_a: assert property (
    ser_bit_s |=> shift_reg[0] == $past(host_bus_in[SER_DATA_BIT]))
    else $error("serial bit not shifted in");
  ser_clear_a: assert property (
    !selected |=> shift_reg == 8'h00 && bit_cnt_reg == 3'h0)
    else $error("serial state kept while deselected");
  bias_cmd_a: assert property (
    pwr_cmd && !in_reset |=> bias_on_chip == ($past(wr_byte[2:0]) != PWR_OFF_FIELD))
    else $error("power command ignored");
endmodule // lcd_host_port

// >>> lcd_port_pkg.sv
package lcd_port_pkg;
  // ==================================================
  // host pin layout
  localparam int BUS_W = 8;
  localparam int SER_DATA_BIT = 7;
  localparam int SER_CLK_BIT = 6;
  localparam logic [2:0] SER_LAST_BIT = 3'h7;

  // ==================================================
  // apb register map, byte addresses
  localparam logic [7:0] STATUS_BYTE_ADDR = 8'h00;
  localparam logic [7:0] READ_BYTE_ADDR = 8'h04;
  localparam logic [7:0] CMD_LAST_ADDR = 8'h08;
  localparam logic [7:0] DATA_LAST_ADDR = 8'h0C;
  localparam logic [7:0] PORT_STATE_ADDR = 8'h10;

  // ==================================================
  // reset values and command decode
  localparam logic [7:0] STATUS_BYTE_RST = 8'h00;
  localparam logic [7:0] READ_BYTE_RST = 8'h00;
  localparam logic BIAS_ON_CHIP_RST = 1'b0;
  localparam logic [7:0] PWR_CTRL_MASK = 8'hF8;
  localparam logic [7:0] PWR_CTRL_CODE = 8'h28;
  localparam logic [2:0] PWR_OFF_FIELD = 3'h0;

  // ==================================================
  // types
  typedef enum logic [1:0] {MODE_RESET, MODE_SEP, MODE_ENA, MODE_SER} mode_t;
  typedef enum logic [1:0] {K_DATA_RD, K_DATA_WR, K_STAT_RD, K_CMD_WR} kind_t;

  typedef struct packed {
    logic cmd_data_select;
    logic chip_select_low_n;
    logic chip_select_high;
    logic rd_strobe_n;
    logic wr_strobe_n;
    logic iface_strap_first;
    logic iface_strap_second;
  } host_ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// >>> tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_port_pkg::*;
  typedef struct packed {logic f; logic s; logic rd; logic cds; logic [7:0] val;} row_t;
  logic ref_clk;
  logic rst;
  host_ctrl_t host_ctrl;
  apb_req_t apb_req;
  logic [7:0] host_bus_in;
  logic [7:0] host_bus_out;
  logic [7:0] host_bus_oe;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bias_on_chip;
  int oe_hits = 0;
  int oe_base;
  logic eb;
  logic [32:0] rd;
  logic [7:0] rb;
  logic [7:0] cn;
  logic [7:0] dn;
  logic [1:0] cur;
  row_t r;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  // straps, read, select nibble then byte: sep, enable, serial
  row_t rows [12] = '{12'h411, 12'h596, 12'h6A5, 12'h73C, 12'hC2F, 12'hD69,
                      12'hEA5, 12'hF3C, 12'h82D, 12'h9C3, 12'hAA5, 12'hB3C};
  lcd_host_port lcd_host_port_inst (.ref_clk(ref_clk), .rst(rst), .host_bus_in(host_bus_in),
    .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .host_ctrl(host_ctrl),
    .bias_on_chip(bias_on_chip), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  host_model host_model_inst (.ref_clk(ref_clk), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe), .host_ctrl(host_ctrl), .host_bus_in(host_bus_in));
  // ==========
  // helpers
  task automatic complete_run();
    $display("failures=%0d total_checks=%0d", failures, total_checks);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // apb transfer; rd gets {pslverr, prdata}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = {pslverr, prdata};
    apb_req <= '0;
  endtask
  // clock, drive watch, hang guard
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (host_bus_oe !== 8'h00) oe_hits <= oe_hits + 1;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      complete_run();
    end
  end
  // ==========
  // main sequence
  initial begin
    rst = 1'b1;
    apb_req = '0;
    cn = 8'h00;
    dn = 8'h00;
    cur = 2'b00;
    eb = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      chk(rd, {a == 5, 32'h0}, "reset or unmapped");
    end
    apb(1'b1, STATUS_BYTE_ADDR, 32'hFFFFFFA5);
    apb(1'b1, READ_BYTE_ADDR, 32'h3C);
    apb(1'b1, CMD_LAST_ADDR, 32'hFF);
    apb(1'b0, STATUS_BYTE_ADDR, 32'h0);
    chk(rd, 33'hA5, "status reg");
    apb(1'b0, CMD_LAST_ADDR, 32'h0);
    chk(rd, 33'h0, "read only");
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      if ({r.f, r.s} !== cur) begin
        host_model_inst.straps(r.f, r.s);
        cur = {r.f, r.s};
        apb(1'b0, PORT_STATE_ADDR, 32'h0);
        chk(rd[1:0], {r.f, r.f ^ r.s}, "mode");
      end
      oe_base = oe_hits;
      if (r.f & !r.s & !r.rd)
        host_model_inst.ser_byte(r.cds, r.val, 8);
      else
        host_model_inst.xfer(r.rd, r.cds, r.val, rb);
      chk(oe_hits != oe_base, r.rd & !(r.f & !r.s), "drive");
      if (r.rd & !(r.f & !r.s))
        chk(rb, r.val, "read byte");
      if (!r.rd) begin
        if (r.cds)
          dn++;
        else
          cn++;
        if (!r.cds && (r.val & PWR_CTRL_MASK) == PWR_CTRL_CODE)
          eb = (r.val[2:0] != PWR_OFF_FIELD);
        apb(1'b0, r.cds ? DATA_LAST_ADDR : CMD_LAST_ADDR, 32'h0);
        chk(rd, {17'h0, r.cds ? dn : cn, r.val}, "last byte");
        chk(bias_on_chip, eb, "bias");
      end
    end
    // reset strap state ignores the bus
    host_model_inst.straps(1'b0, 1'b0);
    host_model_inst.xfer(1'b0, 1'b0, 8'h2F, rb);
    chk(bias_on_chip, 1'b0, "bias in reset state");
    apb(1'b0, CMD_LAST_ADDR, 32'h0);
    chk(rd, {17'h0, cn, 8'h2D}, "reset state write");
    // broken frame then a whole one
    host_model_inst.straps(1'b1, 1'b0);
    host_model_inst.ser_byte(1'b0, 8'h5A, 5);
    apb(1'b0, PORT_STATE_ADDR, 32'h0);
    chk(rd[5:3], 3'h0, "bit count cleared");
    host_model_inst.ser_byte(1'b1, 8'hE7, 8);
    dn++;
    apb(1'b0, DATA_LAST_ADDR, 32'h0);
    chk(rd, {17'h0, dn, 8'hE7}, "frame after abort");
    // power command on, then off, over the serial port
    host_model_inst.ser_byte(1'b0, 8'h2F, 8);
    chk(bias_on_chip, 1'b1, "bias on");
    host_model_inst.ser_byte(1'b0, 8'h28, 8);
    cn = cn + 8'h02;
    chk(bias_on_chip, 1'b0, "bias off");
    // one select inactive blocks the frame
    host_model_inst.cs_block = 1'b1;
    host_model_inst.ser_byte(1'b0, 8'h2F, 8);
    apb(1'b0, CMD_LAST_ADDR, 32'h0);
    chk(rd, {17'h0, cn, 8'h28}, "half selected");
    chk(bias_on_chip, 1'b0, "bias kept");
    complete_run();
  end
endmodule // tb
